/* hw/pitr_pkg.sv */
// Package: constants and types for the PMIC I2C target register port
package pitr_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // Spike width to be suppressed, in ns
    localparam int unsigned GLITCH_NS = 50;
    // Filter length: samples that must agree before a level is taken
    localparam int unsigned GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000 + 1;
    localparam logic [2:0] FILT_LEN = 3'(GLITCH_CYC);
    localparam logic [6:0] RTC_ADDR_RST = 7'h6f;
    localparam logic [6:0] MAIN_ADDR_RST = 7'h12;
    localparam logic [6:0] ADDR_MIN = 7'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [7:0] PTR_RST = 8'h00;

    typedef enum logic [2:0] {
        PITR_IDLE,
        PITR_DEVADDR,
        PITR_REGADDR,
        PITR_WDATA,
        PITR_RDATA,
        PITR_RACK
    } pitr_phase_e;
endpackage

/* hw/pitr_line_if.sv */
// Interface: one filtered bus line with its edge strobes
`timescale 1ns/10ps
interface pitr_line_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

/* hw/pitr_line_filter.sv */
// Synchroniser and spike filter for one bus line
`timescale 1ns/10ps
module pitr_line_filter
    import pitr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic line_i,
    pitr_line_if.src out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [2:0] cnt;
        logic level;
        logic rise;
        logic fall;
    } pitr_filt_s;

    pitr_filt_s st;
    pitr_filt_s next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = line_i;
        next_st.s2 = st.s1;
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        if (st.s2 == st.level) begin
            next_st.cnt = 3'h0;
        end else if (st.cnt + 3'h1 >= FILT_LEN) begin
            next_st.cnt = 3'h0;
            next_st.level = st.s2;
            next_st.rise = st.s2;
            next_st.fall = ~st.s2;
        end else begin
            next_st.cnt = st.cnt + 3'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '{s1: 1'b1, s2: 1'b1, cnt: 3'h0, level: 1'b1, rise: 1'b0, fall: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign out.level = st.level;
    assign out.rise = st.rise;
    assign out.fall = st.fall;

    AST_SPIKE_DROPPED: assert property (@(posedge clock_i) disable iff (rst_i)
        (st.s2 != st.level) && (st.cnt == 3'h0) ##1 (st.s2 == st.level) |=> $stable(st.level))
        else $error("Short spike changed the filtered level");
endmodule

/* hw/pitr_target.sv */
// I2C target register port: top level
`timescale 1ns/10ps
module pitr_target
    import pitr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic io_supply_good_i,
    input wire logic recall_busy_i,
    input wire logic nvm_prog_busy_i,
    input wire logic addr_load_i,
    input wire logic [6:0] rtc_addr_i,
    input wire logic [6:0] main_addr_i,
    output logic bus_busy_o,
    output logic reg_wr_o,
    output logic reg_rtc_sel_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_impl_i,
    output logic stop_o
);
    // ------------------------------------------------------------
    // Line conditioning
    // ------------------------------------------------------------
    pitr_line_if scl_l ();
    pitr_line_if sda_l ();

    pitr_line_filter u_scl_filt (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .line_i(scl_i),
        .out(scl_l)
    );
    pitr_line_filter u_sda_filt (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .line_i(sda_i),
        .out(sda_l)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pitr_phase_e phase;
        logic busy;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic rw;
        logic rtc_sel;
        logic [7:0] ptr;
        logic ack_drive;
        logic sda_drv;
        logic [6:0] rtc_addr;
        logic [6:0] main_addr;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] waddr;
        logic stop;
    } pitr_state_s;

    pitr_state_s st;
    pitr_state_s next_st;

    logic start_ev;
    logic stop_ev;
    logic refuse;
    logic match_rtc;
    logic match_main;
    logic [7:0] rd_byte;
    logic [7:0] byte_in;

    assign start_ev = scl_l.level & sda_l.fall & io_supply_good_i;
    assign stop_ev = scl_l.level & sda_l.rise;
    assign refuse = recall_busy_i | nvm_prog_busy_i;
    assign byte_in = {st.shift[6:0], sda_l.level};
    // Address byte is complete in the shifter by the ACK slot
    assign match_rtc = (st.shift[7:1] == st.rtc_addr);
    assign match_main = (st.shift[7:1] == st.main_addr);
    assign rd_byte = reg_impl_i ? reg_rdata_i : ZERO_BYTE;

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wr = 1'b0;
        next_st.stop = 1'b0;
        if (addr_load_i) begin
            // Out-of-range values keep the current address
            if (rtc_addr_i >= ADDR_MIN) begin
                next_st.rtc_addr = rtc_addr_i;
            end
            if (main_addr_i >= ADDR_MIN) begin
                next_st.main_addr = main_addr_i;
            end
        end
        if (!io_supply_good_i) begin
            next_st.phase = PITR_IDLE;
            next_st.busy = 1'b0;
            next_st.sda_drv = 1'b0;
        end else if (start_ev) begin
            next_st.phase = PITR_DEVADDR;
            next_st.busy = 1'b1;
            next_st.bitn = BIT_CNT_RST;
            next_st.ack_drive = 1'b0;
            next_st.sda_drv = 1'b0;
        end else if (stop_ev) begin
            next_st.phase = PITR_IDLE;
            next_st.busy = 1'b0;
            next_st.sda_drv = 1'b0;
            next_st.stop = st.busy;
        // No timeouts: the engine steps only on filtered edges and on loss of IO supply good
        end else if (scl_l.rise) begin
            case (st.phase)
                PITR_DEVADDR, PITR_REGADDR, PITR_WDATA: begin
                    if (st.bitn < BIT_ACK) begin
                        next_st.shift = byte_in;
                        next_st.bitn = st.bitn + 4'h1;
                    end
                end
                PITR_RDATA: begin
                    if (st.bitn < BIT_ACK) begin
                        next_st.bitn = st.bitn + 4'h1;
                    end else if (sda_l.level) begin
                        next_st.phase = PITR_IDLE;
                    end else begin
                        next_st.bitn = BIT_CNT_RST;
                    end
                end
                PITR_IDLE, PITR_RACK: begin
                    next_st.phase = st.phase;
                end
                default: begin
                    next_st.phase = PITR_IDLE;
                end
            endcase
        end else if (scl_l.fall) begin
            next_st.sda_drv = 1'b0;
            case (st.phase)
                PITR_DEVADDR: begin
                    if (st.ack_drive) begin
                        next_st.ack_drive = 1'b0;
                        next_st.bitn = BIT_CNT_RST;
                        if (st.rw) begin
                            next_st.phase = PITR_RDATA;
                            next_st.shift = rd_byte;
                            next_st.sda_drv = ~rd_byte[7];
                            next_st.ptr = st.ptr + 8'h01;
                        end else begin
                            next_st.phase = PITR_REGADDR;
                        end
                    end else if (st.bitn == BIT_ACK) begin
                        if ((match_rtc | match_main) & ~refuse) begin
                            next_st.ack_drive = 1'b1;
                            next_st.sda_drv = 1'b1;
                            next_st.rw = st.shift[0];
                            // Shared address reaches the main set
                            next_st.rtc_sel = ~(st.shift[7:1] == st.main_addr);
                        end else begin
                            next_st.phase = PITR_IDLE;
                        end
                    end
                end
                PITR_REGADDR, PITR_WDATA: begin
                    if (st.ack_drive) begin
                        next_st.ack_drive = 1'b0;
                        next_st.bitn = BIT_CNT_RST;
                        next_st.phase = PITR_WDATA;
                    end else if (st.bitn == BIT_ACK) begin
                        if (refuse) begin
                            next_st.phase = PITR_IDLE;
                        end else begin
                            next_st.ack_drive = 1'b1;
                            next_st.sda_drv = 1'b1;
                            if (st.phase == PITR_REGADDR) begin
                                next_st.ptr = st.shift;
                            end else begin
                                next_st.wr = 1'b1;
                                next_st.wdata = st.shift;
                                next_st.waddr = st.ptr;
                                next_st.ptr = st.ptr + 8'h01;
                            end
                        end
                    end
                end
                PITR_RDATA: begin
                    if (st.bitn == BIT_ACK) begin
                        next_st.sda_drv = 1'b0;
                    end else if (st.bitn == BIT_CNT_RST) begin
                        next_st.shift = rd_byte;
                        next_st.sda_drv = ~rd_byte[7];
                        next_st.ptr = st.ptr + 8'h01;
                    end else begin
                        next_st.shift = {st.shift[6:0], 1'b0};
                        next_st.sda_drv = ~st.shift[6];
                    end
                end
                PITR_IDLE, PITR_RACK: begin
                    next_st.sda_drv = 1'b0;
                end
                default: begin
                    next_st.phase = PITR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '{phase: PITR_IDLE, busy: 1'b0, bitn: BIT_CNT_RST, shift: ZERO_BYTE,
                rw: 1'b0, rtc_sel: 1'b0, ptr: PTR_RST, ack_drive: 1'b0, sda_drv: 1'b0,
                rtc_addr: RTC_ADDR_RST, main_addr: MAIN_ADDR_RST, wr: 1'b0,
                wdata: ZERO_BYTE, waddr: PTR_RST, stop: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read address: current pointer, captured when a byte is loaded
    assign sda_o = 1'b0;
    assign sda_oe_o = st.sda_drv;
    assign bus_busy_o = st.busy;
    assign reg_wr_o = st.wr;
    assign reg_rtc_sel_o = st.rtc_sel;
    assign reg_addr_o = st.wr ? st.waddr : st.ptr;
    assign reg_wdata_o = st.wdata;
    assign stop_o = st.stop;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BUSY_ON_START: assert property (@(posedge clock_i) disable iff (rst_i)
        start_ev |=> st.busy) else $error("Bus not busy after start");
    AST_FREE_ON_STOP: assert property (@(posedge clock_i) disable iff (rst_i)
        stop_ev && !start_ev |=> !st.busy) else $error("Bus busy after stop");
    AST_RESTART_ADDR: assert property (@(posedge clock_i) disable iff (rst_i)
        st.busy && start_ev |=> st.phase == PITR_DEVADDR && st.bitn == 4'h0)
        else $error("Repeated start did not restart address phase");
    AST_NO_ACK_REFUSED: assert property (@(posedge clock_i) disable iff (rst_i)
        io_supply_good_i && !start_ev && !stop_ev && scl_l.fall &&
        st.phase == PITR_DEVADDR && st.bitn == 4'h8 && !st.ack_drive && refuse
        |=> !sda_oe_o) else $error("Acknowledged while busy");
    AST_NO_ACK_BUSY_DATA: assert property (@(posedge clock_i) disable iff (rst_i)
        io_supply_good_i && !start_ev && !stop_ev && scl_l.fall && refuse && !st.ack_drive &&
        (st.phase == PITR_REGADDR || st.phase == PITR_WDATA) && st.bitn == 4'h8
        |=> !sda_oe_o && !reg_wr_o) else $error("Acknowledged data while busy");
    AST_WRITE_INC: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_o |-> st.ptr == reg_addr_o + 8'h01)
        else $error("Pointer did not advance after write");
    AST_WR_PULSE: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_o |=> !reg_wr_o) else $error("Write strobe longer than one cycle");
    AST_IDLE_NO_DRIVE: assert property (@(posedge clock_i) disable iff (rst_i)
        st.phase == PITR_IDLE |-> !sda_oe_o) else $error("Driving SDA when idle");
    AST_SUPPLY_GATE: assert property (@(posedge clock_i) disable iff (rst_i)
        !io_supply_good_i |=> !st.busy && !sda_oe_o)
        else $error("Active without IO supply good");
    AST_RD_RELEASE: assert property (@(posedge clock_i) disable iff (rst_i)
        io_supply_good_i && !start_ev && !stop_ev && scl_l.fall &&
        st.phase == PITR_RDATA && st.bitn == 4'h8 |=> !sda_oe_o)
        else $error("SDA held in read acknowledge slot");

    COV_WRITE: cover property (@(posedge clock_i) reg_wr_o);
    COV_READ: cover property (@(posedge clock_i) st.phase == PITR_RDATA);
    COV_RESTART: cover property (@(posedge clock_i) st.busy && start_ev);
    COV_STOP: cover property (@(posedge clock_i) stop_o);
    COV_REFUSED: cover property (@(posedge clock_i) refuse && scl_l.fall && st.bitn == 4'h8);
endmodule

/* test/pitr_ctrl_model.sv */
// Bus controller model: drives SCL and pulls SDA low, open drain
`timescale 1ns/10ps
module pitr_ctrl_model (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    localparam int HALF = 10;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(negedge clock_i);
    endtask
    // Works from idle and as a repeated start
    task automatic start();
        repeat (2) @(negedge clock_i);
        sda_low_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_low_o = 1'b1;
        hold();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(negedge clock_i);
        sda_low_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_low_o = 1'b0;
        hold();
    endtask
    // SDA changes only with SCL low, some hold after the fall
    task automatic bit_io(input logic b, output logic s);
        repeat (2) @(negedge clock_i);
        sda_low_o = !b;
        hold();
        scl_o = 1'b1;
        hold();
        s = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // Acknowledge when more bytes wanted, else leave SDA high
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, s);
            d = {d[6:0], s};
        end
        bit_io(!more, s);
    endtask
endmodule

/* test/tb_pitr_target.sv */
// Self-checking testbench for the I2C target register port
`timescale 1ns/10ps
module tb_pitr_target;
    import pitr_pkg::*;
    logic clock_i, rst_i, scl, ctrl_low, glitch_low, supply, recall, nvm, addr_load;
    logic [6:0] rtc_addr, main_addr;
    logic sda_o, sda_oe_o, bus_busy_o, reg_wr_o, reg_rtc_sel_o, stop_o;
    logic [7:0] reg_addr_o, reg_wdata_o;
    wire logic sda_w;
    wire logic impl;
    wire logic [7:0] rdata;
    int errors = 0;
    int tests_run = 0;
    int stop_cnt = 0;
    logic [7:0] mem [0:15];
    logic [16:0] wlog [$];

    assign sda_w = !(ctrl_low || (sda_oe_o && !sda_o) || glitch_low);
    assign impl = reg_addr_o < 8'h10;
    assign rdata = impl ? mem[reg_addr_o[3:0]] : 8'hee;

    pitr_target dut_u (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .io_supply_good_i(supply),
        .recall_busy_i(recall), .nvm_prog_busy_i(nvm), .addr_load_i(addr_load),
        .rtc_addr_i(rtc_addr), .main_addr_i(main_addr), .bus_busy_o(bus_busy_o),
        .reg_wr_o(reg_wr_o), .reg_rtc_sel_o(reg_rtc_sel_o), .reg_addr_o(reg_addr_o),
        .reg_wdata_o(reg_wdata_o), .reg_rdata_i(rdata), .reg_impl_i(impl), .stop_o(stop_o));
    pitr_ctrl_model ctrl_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
        .sda_low_o(ctrl_low));

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Strobes sampled mid-cycle, away from the launching edge
    always @(negedge clock_i) begin
        if (reg_wr_o === 1'b1) begin
            wlog.push_back({reg_rtc_sel_o, reg_addr_o, reg_wdata_o});
            if (reg_addr_o < 8'h10) mem[reg_addr_o[3:0]] <= reg_wdata_o;
        end
        if (stop_o === 1'b1) stop_cnt++;
    end

    task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic sb(input logic [7:0] d, input logic exp, input string nm);
        logic a;
        ctrl_u.send_byte(d, a);
        chk(nm, {16'h0, exp}, {16'h0, a});
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_glitch();
        glitch_low = 1'b1;
        @(negedge clock_i);
        glitch_low = 1'b0;
        repeat (12) @(negedge clock_i);
        chk("busy after spike", 17'h0, {16'h0, bus_busy_o});
    endtask
    task automatic t_write();
        int n;
        n = stop_cnt;
        wlog.delete();
        ctrl_u.start();
        chk("busy after start", 17'h1, {16'h0, bus_busy_o});
        sb(8'h24, 1'b1, "main address ack");
        sb(8'h05, 1'b1, "register address ack");
        sb(8'ha5, 1'b1, "data ack 0");
        sb(8'h3c, 1'b1, "data ack 1");
        ctrl_u.stop();
        chk("busy after stop", 17'h0, {16'h0, bus_busy_o});
        chk("stop pulse", 17'(n + 1), 17'(stop_cnt));
        chk("write count", 17'h2, 17'(wlog.size()));
        chk("write 0", {1'b0, 8'h05, 8'ha5}, wlog[0]);
        chk("write 1", {1'b0, 8'h06, 8'h3c}, wlog[1]);
    endtask
    task automatic t_read();
        logic [7:0] d;
        ctrl_u.start();
        sb(8'hde, 1'b1, "rtc address ack");
        sb(8'h0e, 1'b1, "read pointer ack");
        ctrl_u.start();
        chk("busy over repeated start", 17'h1, {16'h0, bus_busy_o});
        sb(8'hdf, 1'b1, "read address ack");
        ctrl_u.recv_byte(1'b1, d);
        chk("read 0e", 17'h4e, {9'h0, d});
        ctrl_u.recv_byte(1'b1, d);
        chk("read 0f", 17'h4f, {9'h0, d});
        ctrl_u.recv_byte(1'b0, d);
        chk("read unimplemented", 17'h0, {9'h0, d});
        ctrl_u.stop();
        chk("busy after read", 17'h0, {16'h0, bus_busy_o});
    endtask
    task automatic t_partial();
        logic s;
        wlog.delete();
        ctrl_u.start();
        sb(8'h24, 1'b1, "address ack");
        sb(8'h08, 1'b1, "register ack");
        sb(8'h5a, 1'b1, "full byte ack");
        for (int i = 0; i < 4; i++) ctrl_u.bit_io(1'b1, s);
        ctrl_u.stop();
        chk("partial write count", 17'h1, 17'(wlog.size()));
        chk("kept write", {1'b0, 8'h08, 8'h5a}, wlog[0]);
    endtask
    task automatic t_refuse();
        for (int k = 0; k < 4; k++) begin
            supply = (k != 1);
            recall = (k == 2);
            nvm = (k == 3);
            wlog.delete();
            ctrl_u.start();
            if (k == 1) chk("busy without supply", 17'h0, {16'h0, bus_busy_o});
            sb((k == 0) ? 8'h66 : 8'h24, 1'b0, "refused address");
            sb(8'h07, 1'b0, "byte after refusal");
            sb(8'h99, 1'b0, "data after refusal");
            ctrl_u.stop();
            chk("refused writes", 17'h0, 17'(wlog.size()));
        end
        supply = 1'b1;
        recall = 1'b0;
        nvm = 1'b0;
        ctrl_u.start();
        sb(8'h24, 1'b1, "address before busy");
        nvm = 1'b1;
        sb(8'h09, 1'b0, "register byte while busy");
        ctrl_u.stop();
        nvm = 1'b0;
        chk("busy refused writes", 17'h0, 17'(wlog.size()));
    endtask
    task automatic load(input logic [6:0] r, input logic [6:0] m);
        rtc_addr = r;
        main_addr = m;
        addr_load = 1'b1;
        @(negedge clock_i);
        addr_load = 1'b0;
    endtask
    task automatic t_addr_load();
        wlog.delete();
        load(7'h22, 7'h22);
        ctrl_u.start();
        sb(8'h44, 1'b1, "shared address ack");
        sb(8'h02, 1'b1, "register ack");
        sb(8'h77, 1'b1, "data ack");
        ctrl_u.start();
        sb(8'h24, 1'b0, "old address refused");
        ctrl_u.stop();
        load(7'h00, 7'h12);
        ctrl_u.start();
        sb(8'h44, 1'b1, "kept rtc address ack");
        sb(8'h03, 1'b1, "register ack");
        sb(8'h11, 1'b1, "data ack");
        ctrl_u.stop();
        chk("shared write", {1'b0, 8'h02, 8'h77}, wlog[0]);
        chk("rtc write", {1'b1, 8'h03, 8'h11}, wlog[1]);
    endtask

    initial begin
        rst_i = 1'b1;
        glitch_low = 1'b0;
        supply = 1'b1;
        recall = 1'b0;
        nvm = 1'b0;
        addr_load = 1'b0;
        rtc_addr = 7'h00;
        main_addr = 7'h00;
        for (int i = 0; i < 16; i++) mem[i] = 8'h40 + 8'(i);
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clock_i);
        t_glitch();
        t_write();
        t_read();
        t_partial();
        t_refuse();
        t_addr_load();
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        errors++;
        $display("Error watchdog expected done seen hang");
        test_done();
    end
endmodule
